// *** core/rsr_params.svh ***
`ifndef RSR_PARAMS_SVH
`define RSR_PARAMS_SVH
// Register offsets on the serial port (6-bit address field)
`define RSR_ADDR_TUNE_HIGH 6'h2D
`define RSR_ADDR_TUNE_LOW 6'h2E
`define RSR_ADDR_PART 6'h30
`define RSR_ADDR_REV 6'h31
`define RSR_ADDR_FREQ_EST 6'h32
`define RSR_ADDR_LQI 6'h33
`define RSR_ADDR_SIGNAL_STRENGTH_LEVEL 6'h34
`define RSR_ADDR_FSM 6'h35
`define RSR_ADDR_STATUS_BASE 6'h30
// Reset values
`define RSR_TUNE_HIGH_RST 8'h31
`define RSR_TUNE_HIGH_RET 8'h35
`define RSR_TUNE_LOW_RST 8'h0B
// Field positions
`define RSR_HDR_READ_BIT 7
`define RSR_HDR_BURST_BIT 6
`define RSR_OSC_CAL_EN_BIT 1
`define RSR_CRC_OK_BIT 7
// Radio controller state codes
`define RSR_FSM_SLEEP 5'h00
`define RSR_FSM_IDLE 5'h01
`define RSR_FSM_CRYSTAL_OFF_STATE 5'h02
`define RSR_FSM_RX 5'h0D
`define RSR_FSM_RX_OVERFLOW 5'h11
`define RSR_FSM_TX 5'h13
`define RSR_FSM_TX_UNDERFLOW 5'h16
// Link quality averaging window in symbols
`define RSR_LQI_SYMBOLS 64
`endif

// *** core/rsr_pkg.sv ***
package rsr_pkg;
  // Live demodulator and controller status, all on the system clock
  typedef struct packed {
    logic [7:0] freq_est;
    logic fsk_mode;
    logic [7:0] signal_strength_level;
    logic [4:0] fsm_state;
  } rsr_demod_s;

  // Per-symbol quality stream behind the sync word
  typedef struct packed {
    logic sync_found;
    logic sym_valid;
    logic [6:0] sym_quality;
  } rsr_symq_s;

  // Serial port byte phase
  typedef enum logic {
    RSR_PH_HEADER,
    RSR_PH_DATA
  } rsr_phase_e;
endpackage

// *** core/rsr_status_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rsr_params.svh"
// How it works
// - Wake from low power forces internal analog tune high to 0x31 or 0x35.
// - Host reads of analog tune high return 0x31 after wake; inversion stays internal.
// - Analog tune low bit 1, reset one, enables oscillator-select calibration stage.
// - Two read-only bytes give part code and silicon revision code.
// - Carrier offset reads as 8-bit two's complement, step crystal over 2^14.
// - Carrier offset reads zero unless frequency-shift or minimum-shift modulation.
// - Link quality bit 7 shows last CRC match, cleared on receive entry.
// - Link quality low 7 bits average 64 symbols following sync detection.
// - Signal strength register holds the current 8-bit strength indication.
// - Controller state reads as 5-bit code, upper three bits zero.
// - Chip select low during sleep or crystal-off wakes the device to idle.
module rsr_status_regs
  import rsr_pkg::*;
#(
  parameter int LQI_SYMBOLS = `RSR_LQI_SYMBOLS,
  parameter logic [7:0] PART_CODE = 8'hA5, // Arbitrary value
  parameter logic [7:0] REV_CODE = 8'h5A // Arbitrary value
)(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic chip_select_low_active_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire rsr_demod_s demod_i,
  input wire rsr_symq_s symq_i,
  input wire logic crc_done_i,
  input wire logic crc_match_i,
  input wire logic rx_enter_i,
  input wire logic low_power_i,
  input wire logic analog_retention_setting_i,
  output logic wake_o,
  output logic [7:0] analog_tune_high_o,
  output logic [7:0] analog_tune_low_o,
  output logic osc_select_cal_enable_o
);
  localparam int LQI_W = $clog2(LQI_SYMBOLS);

  // ==========================================================
  // Parameter checks
  // The average divides by shifting, so only a power-of-two window works
  if (LQI_SYMBOLS < 2 || (1 << LQI_W) != LQI_SYMBOLS)
    $error("LQI_SYMBOLS must be a power of two");

  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [1:0] csn_sync_ff;
  logic [1:0] sclk_sync_ff;
  logic [1:0] mosi_sync_ff;
  logic csn_d_ff;
  logic sclk_d_ff;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // Pins are asynchronous to clk_i, so each passes two flops first
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      csn_sync_ff <= 2'h3;
      sclk_sync_ff <= 2'h0;
      mosi_sync_ff <= 2'h0;
      csn_d_ff <= 1'b1;
      sclk_d_ff <= 1'b0;
    end
    else
    begin
      csn_sync_ff <= {csn_sync_ff[0], chip_select_low_active_i};
      sclk_sync_ff <= {sclk_sync_ff[0], spi_sclk_i};
      mosi_sync_ff <= {mosi_sync_ff[0], spi_mosi_i};
      csn_d_ff <= csn_sync_ff[1];
      sclk_d_ff <= sclk_sync_ff[1];
    end
  end

  // Edge strobes; sclk must run well under clk_i/4 for this sampling
  wire cs_active = !csn_sync_ff[1];
  wire cs_fall = csn_d_ff && !csn_sync_ff[1];
  wire sclk_rise = cs_active && sclk_sync_ff[1] && !sclk_d_ff;
  wire sclk_fall = cs_active && !sclk_sync_ff[1] && sclk_d_ff;

  // ==========================================================
  // Register storage and status capture
  logic [7:0] tune_high_ff;
  logic [7:0] tune_low_ff;
  logic retain_inv_ff;
  logic crc_ok_ff;
  logic [6:0] lqi_ff;
  logic [LQI_W+6:0] lqi_sum_ff;
  logic [LQI_W-1:0] lqi_cnt_ff;
  logic lqi_run_ff;

  // Serial port state
  rsr_phase_e phase_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic [5:0] addr_ff;
  logic is_read_ff;
  logic is_burst_ff;
  logic miso_ff;
  logic miso_oe_ff;
  logic wake_ff;

  // Read mux shared by header and burst continuation
  function automatic logic [7:0] rd_value(input logic [5:0] a);
    case (a)
      `RSR_ADDR_TUNE_HIGH: rd_value = tune_high_ff;
      `RSR_ADDR_TUNE_LOW: rd_value = tune_low_ff;
      `RSR_ADDR_PART: rd_value = PART_CODE;
      `RSR_ADDR_REV: rd_value = REV_CODE;
      `RSR_ADDR_FREQ_EST: rd_value = demod_i.fsk_mode ? demod_i.freq_est : 8'h00;
      `RSR_ADDR_LQI: rd_value = {crc_ok_ff, lqi_ff};
      `RSR_ADDR_SIGNAL_STRENGTH_LEVEL: rd_value = demod_i.signal_strength_level;
      `RSR_ADDR_FSM: rd_value = {3'h0, demod_i.fsm_state};
      default: rd_value = 8'h00;
    endcase
  endfunction

  wire [7:0] rx_byte = {rx_sh_ff[6:0], mosi_sync_ff[1]};
  wire byte_done = sclk_rise && (bit_cnt_ff == 3'h7);
  // status range is reachable only with the burst flag
  wire hdr_status_strobe = (rx_byte[5:0] >= `RSR_ADDR_STATUS_BASE)
                           && !rx_byte[`RSR_HDR_BURST_BIT];
  wire [5:0] next_addr = (phase_ff == RSR_PH_HEADER) ? rx_byte[5:0] : addr_ff + 6'h01;
  // Single access without burst keeps its address, so a second byte repeats it
  wire [5:0] sel_addr = (phase_ff == RSR_PH_DATA && !is_burst_ff) ? addr_ff : next_addr;
  // header phase shifts out status; data bits only for a true read
  wire miso_gate = (phase_ff == RSR_PH_HEADER) || is_read_ff;
  wire do_write = byte_done && (phase_ff == RSR_PH_DATA) && !is_read_ff;
  wire wake_evt = cs_fall && low_power_i;
  wire [7:0] status_byte = {3'h0, demod_i.fsm_state};

  // chip select low while asleep wakes the controller
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      wake_ff <= 1'b0;
    else
      wake_ff <= wake_evt;
  end

  // Analog tune storage; wake restores the host-visible reset value
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tune_high_ff <= `RSR_TUNE_HIGH_RST;
      tune_low_ff <= `RSR_TUNE_LOW_RST;
      retain_inv_ff <= 1'b0;
    end
    else if (wake_evt)
    begin
      // readback reset, retention choice held internally
      tune_high_ff <= `RSR_TUNE_HIGH_RST;
      retain_inv_ff <= analog_retention_setting_i;
    end
    else if (do_write && addr_ff == `RSR_ADDR_TUNE_HIGH)
    begin
      tune_high_ff <= rx_byte;
      retain_inv_ff <= 1'b0;
    end
    else if (do_write && addr_ff == `RSR_ADDR_TUNE_LOW)
      tune_low_ff <= rx_byte;
  end

  // Analog-side copies; retention variant differs only on this path
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      analog_tune_high_o <= `RSR_TUNE_HIGH_RST;
      analog_tune_low_o <= `RSR_TUNE_LOW_RST;
      osc_select_cal_enable_o <= 1'b1;
    end
    else
    begin
      // retention value seen only by analog
      analog_tune_high_o <= retain_inv_ff ? `RSR_TUNE_HIGH_RET : tune_high_ff;
      analog_tune_low_o <= tune_low_ff;
      osc_select_cal_enable_o <= tune_low_ff[`RSR_OSC_CAL_EN_BIT];
    end
  end

  // CRC flag: a new result wins over a receive-entry clear
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      crc_ok_ff <= 1'b0;
    // last compare, cleared on receive entry
    else if (crc_done_i)
      crc_ok_ff <= crc_match_i;
    else if (rx_enter_i)
      crc_ok_ff <= 1'b0;
  end

  // average quality over the window after sync
  wire [LQI_W+6:0] lqi_sum_nxt = lqi_sum_ff + {{LQI_W{1'b0}}, symq_i.sym_quality};
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lqi_ff <= 7'h00;
      lqi_sum_ff <= '0;
      lqi_cnt_ff <= '0;
      lqi_run_ff <= 1'b0;
    end
    else if (symq_i.sync_found)
    begin
      lqi_sum_ff <= '0;
      lqi_cnt_ff <= '0;
      lqi_run_ff <= 1'b1;
    end
    else if (lqi_run_ff && symq_i.sym_valid)
    begin
      lqi_sum_ff <= lqi_sum_nxt;
      lqi_cnt_ff <= lqi_cnt_ff + 1'b1;
      if (&lqi_cnt_ff)
      begin
        lqi_ff <= lqi_sum_nxt[LQI_W+6:LQI_W];
        lqi_run_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Serial port: header byte then data bytes, auto-increment in burst
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_ff <= RSR_PH_HEADER;
      bit_cnt_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
      tx_sh_ff <= 8'h00;
      addr_ff <= 6'h00;
      is_read_ff <= 1'b0;
      is_burst_ff <= 1'b0;
    end
    else if (!cs_active)
    begin
      phase_ff <= RSR_PH_HEADER;
      bit_cnt_ff <= 3'h0;
    end
    else if (cs_fall)
      tx_sh_ff <= status_byte;
    else if (sclk_rise)
    begin
      rx_sh_ff <= rx_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (byte_done)
      begin
        phase_ff <= RSR_PH_DATA;
        addr_ff <= sel_addr;
        tx_sh_ff <= rd_value(sel_addr);
        if (phase_ff == RSR_PH_HEADER)
        begin
          // plain-form status address is a strobe, read as zero
          is_read_ff <= rx_byte[`RSR_HDR_READ_BIT] && !hdr_status_strobe;
          is_burst_ff <= rx_byte[`RSR_HDR_BURST_BIT];
        end
      end
    end
    else if (sclk_fall && bit_cnt_ff != 3'h0)
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
  end

  // Output bit changes on falling clock so the host samples it stable
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end
    else
    begin
      miso_oe_ff <= cs_active;
      if (cs_fall)
        miso_ff <= status_byte[7];
      else if (sclk_fall)
        miso_ff <= miso_gate && ((bit_cnt_ff == 3'h0) ? tx_sh_ff[7] : tx_sh_ff[6]);
    end
  end

  assign spi_miso_o = miso_ff;
  assign spi_miso_oe_o = miso_oe_ff;
  assign wake_o = wake_ff;
endmodule
`default_nettype wire

// *** test/rsr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// Host serial master, mode 0, four system clocks per half bit
module rsr_host (
  input wire logic clk_i,
  input wire logic spi_miso_i,
  output logic chip_select_low_active_o,
  output logic spi_sclk_o,
  output logic spi_mosi_o
);
  initial
  begin
    chip_select_low_active_o = 1'b1;
    spi_sclk_o = 1'b0;
    spi_mosi_o = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    chip_select_low_active_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_mosi_o = tx[i];
      repeat (4) @(negedge clk_i);
      spi_sclk_o = 1'b1;
      rx[i] = spi_miso_i;
      repeat (4) @(negedge clk_i);
      spi_sclk_o = 1'b0;
    end
    repeat (6) @(negedge clk_i);
    chip_select_low_active_o = 1'b1;
    // Released data line toggles so a stale bit is never read as valid
    spi_mosi_o = ~spi_mosi_o;
    repeat (4) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** test/rsr_status_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port checker
module rsr_status_props (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic chip_select_low_active_i,
  input wire logic spi_miso_oe_o,
  input wire logic low_power_i,
  input wire logic analog_retention_setting_i,
  input wire logic wake_o,
  input wire logic [7:0] analog_tune_high_o,
  input wire logic [7:0] analog_tune_low_o,
  input wire logic osc_select_cal_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  chk_oe_on_select:
    assert property ($fell(chip_select_low_active_i) |-> ##[2:5] spi_miso_oe_o)
    else $error("miso enable late");
  chk_wake_on_select:
    assert property ($fell(chip_select_low_active_i) && low_power_i |-> ##[1:5] wake_o)
    else $error("no wake pulse");
  chk_wake_one_cycle:
    assert property (wake_o |=> !wake_o)
    else $error("wake pulse too long");
  chk_wake_retained:
    assert property (wake_o && analog_retention_setting_i |-> ##[0:2] analog_tune_high_o == 8'h35)
    else $error("tune high not forced to retention value");
  chk_wake_plain:
    assert property (wake_o && !analog_retention_setting_i |-> ##[0:2] analog_tune_high_o == 8'h31)
    else $error("tune high not forced to plain value");
  chk_cal_enable_bit:
    assert property (osc_select_cal_enable_o == analog_tune_low_o[1])
    else $error("calibration enable differs from bit 1");
  chk_tune_low_write:
    assert property (!$stable(analog_tune_low_o) |-> spi_miso_oe_o)
    else $error("tune low changed outside a transfer");
  chk_reset_values:
    assert property ($rose(rstn_i) |-> analog_tune_high_o == 8'h31 &&
      analog_tune_low_o == 8'h0B && osc_select_cal_enable_o)
    else $error("wrong reset values");
endmodule
bind rsr_status_regs rsr_status_props i_props (.clk_i, .rstn_i, .chip_select_low_active_i,
  .spi_miso_oe_o, .low_power_i, .analog_retention_setting_i, .wake_o, .analog_tune_high_o,
  .analog_tune_low_o, .osc_select_cal_enable_o);
`default_nettype wire

// *** test/test_radio_status_test_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench top
module test_radio_status_test_regs;
  import rsr_pkg::*;
  localparam logic [7:0] PART = 8'hC3; // Arbitrary value
  localparam logic [7:0] REV = 8'h3C; // Arbitrary value
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  rsr_demod_s demod = '0;
  rsr_symq_s symq;
  logic sync_found = 1'b0, sym_valid = 1'b0;
  logic [6:0] sym_quality = 7'h00;
  assign symq = {sync_found, sym_valid, sym_quality};
  logic crc_done = 1'b0, crc_match = 1'b0, rx_enter = 1'b0, low_power = 1'b0, ret = 1'b0;
  wire cs_l, sclk, mosi, miso, wake, cal;
  wire [7:0] th, tl;
  int num_errors = 0, num_checks = 0, cyc = 0, wakes = 0;
  logic [4:0] codes [4] = '{5'h0D, 5'h13, 5'h11, 5'h16};
  always #10 clk_i = ~clk_i;
  rsr_status_regs #(.LQI_SYMBOLS(4), .PART_CODE(PART), .REV_CODE(REV)) i_dut (.clk_i,
    .rstn_i, .chip_select_low_active_i(cs_l), .spi_sclk_i(sclk), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(), .demod_i(demod), .symq_i(symq),
    .crc_done_i(crc_done), .crc_match_i(crc_match), .rx_enter_i(rx_enter),
    .low_power_i(low_power), .analog_retention_setting_i(ret), .wake_o(wake),
    .analog_tune_high_o(th), .analog_tune_low_o(tl), .osc_select_cal_enable_o(cal));
  rsr_host i_host (.clk_i, .spi_miso_i(miso), .chip_select_low_active_o(cs_l),
    .spi_sclk_o(sclk), .spi_mosi_o(mosi));
  // Hang guard well above the roughly 2650 cycles the run needs
  always @(posedge clk_i)
  begin
    cyc++;
    if (wake === 1'b1) wakes++;
    if (cyc == 20000)
    begin
      num_errors++;
      close_out;
    end
  end
  task chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    num_checks++;
    if (got !== ex)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task rdc(input logic [7:0] hdr, input logic [7:0] ex, input string nm);
    logic [15:0] r;
    i_host.xfer({hdr, 8'h00}, r);
    chk(nm, ex, r[7:0]);
  endtask
  task wr(input logic [7:0] hdr, input logic [7:0] d);
    logic [15:0] r;
    i_host.xfer({hdr, d}, r);
  endtask
  // One-cycle strobe from the negative edge, then one idle cycle before the next
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
    @(negedge clk_i);
  endtask
  task t_regs;
    chk("cal_en", 8'h01, {7'h00, cal});
    rdc(8'hAE, 8'h0B, "tune_low");
    wr(8'h2E, 8'h09);
    chk("tune_low_o", 8'h09, tl);
    chk("cal_en", 8'h00, {7'h00, cal});
    wr(8'h2D, 8'h77);
    chk("tune_high_o", 8'h77, th);
    wr(8'h30, 8'h00);
    rdc(8'hF0, PART, "part");
    rdc(8'hF1, REV, "revision");
  endtask
  task t_demod;
    demod.freq_est = 8'h9C;
    demod.fsk_mode = 1'b1;
    demod.signal_strength_level = 8'h7E;
    rdc(8'hF2, 8'h9C, "freq_est");
    rdc(8'hF4, 8'h7E, "signal_strength_level");
    rdc(8'hB4, 8'h00, "strobe form");
    demod.fsk_mode = 1'b0;
    rdc(8'hF2, 8'h00, "freq_est ask");
    foreach (codes[k])
    begin
      demod.fsm_state = codes[k];
      rdc(8'hF5, {3'h0, codes[k]}, "fsm state");
    end
  endtask
  task t_link;
    pulse(rx_enter);
    pulse(sync_found);
    for (int q = 1; q <= 4; q++)
    begin
      sym_quality = 7'(10 * q);
      pulse(sym_valid);
    end
    crc_match = 1'b1;
    pulse(crc_done);
    rdc(8'hF3, 8'h99, "crc and quality");
    pulse(rx_enter);
    rdc(8'hF3, 8'h19, "crc cleared");
  endtask
  task t_wake;
    low_power = 1'b1;
    ret = 1'b1;
    rdc(8'hAD, 8'h31, "tune_high read");
    low_power = 1'b0;
    chk("tune_high_o ret", 8'h35, th);
    rdc(8'hAD, 8'h31, "tune_high read");
    low_power = 1'b1;
    ret = 1'b0;
    rdc(8'hAD, 8'h31, "tune_high read");
    low_power = 1'b0;
    chk("tune_high_o", 8'h31, th);
    chk("wake count", 8'h02, 8'(wakes));
  endtask
  task close_out;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_regs;
    t_demod;
    t_link;
    t_wake;
    close_out;
  end
endmodule
`default_nettype wire
